// ---- design/efcc_top.sv ----
`timescale 1ns/1ns
// Operation
// - measurement enable off disables all measurement circuitry
// - boost supply bit switches transformer charging current
// - source bit picks datapath or raw adc
// - bypass bit picks lowpass or peak detector
// - transmit bit sets only; writing zero ignored
// - format 00 stores all twelve bits
// - format 01 stores bits 11..4 unchecked
// - format 10 stores bits 7..0, checks 11..8
// - format 11 stores bits 10..3, checks 11
// - saturated sample stores byte ff instead
// - rollover wraps write pointer to zero
// - after wrap, newest samples overwrite oldest
// - rollover-off bit stops writing at end
// - capture only when echo enabled and blanking expired
module efcc_top
	import efcc_pkg::*;
#(
	parameter int BUF_DEPTH = BUF_BYTES
)
(
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	// axi4-lite register bus
	input  wire logic [AXI_ADDR_W-1:0] awaddr_in,
	input  wire logic                  awvalid_in,
	output logic                       awready_out,
	input  wire logic [31:0]           wdata_in,
	input  wire logic [3:0]            wstrb_in,
	input  wire logic                  wvalid_in,
	output logic                       wready_out,
	output logic [1:0]                 bresp_out,
	output logic                       bvalid_out,
	input  wire logic                  bready_in,
	input  wire logic [AXI_ADDR_W-1:0] araddr_in,
	input  wire logic                  arvalid_in,
	output logic                       arready_out,
	output logic [31:0]                rdata_out,
	output logic [1:0]                 rresp_out,
	output logic                       rvalid_out,
	input  wire logic                  rready_in,
	// sample stream from the datapath and adc
	input  wire logic [11:0]           lowpass_sample_in,
	input  wire logic [11:0]           peak_sample_in,
	input  wire logic [11:0]           adc_sample_in,
	input  wire logic                  sample_valid_in,
	output logic                       sample_ready_out,
	input  wire logic                  blanking_expired_in,
	// serial engine
	input  wire logic                  serial_transmit_done_in,
	output logic                       serial_transmit_enable_out,
	// analog controls
	output efcc_analog_en_t            analog_enable_out,
	output logic                       boost_supply_enable_out,
	output logic                       filter_bypass_select_out,
	// sample ram write port
	output efcc_buf_wr_t               buf_write_out
);

	typedef enum logic [1:0]
	{
		ST_TAKE  = 2'b01,
		ST_UPPER = 2'b10
	} efcc_state_t;

	localparam logic [9:0] LAST_ADDR = 10'(BUF_DEPTH - 1);

	// register bus wiring
	logic                  reg_wr;
	logic [AXI_ADDR_W-1:0] reg_wr_addr;
	logic [31:0]           reg_wr_data;
	logic [3:0]            reg_wr_strb;
	logic [AXI_ADDR_W-1:0] reg_rd_addr;
	logic [31:0]           reg_rd_data;

	// software state
	logic [7:0]  power_mode_control;
	logic [7:0]  datapath_source_control;
	logic [7:0]  sample_buffer_control;
	logic [7:0]  enable_control;

	// capture state
	efcc_state_t state;
	efcc_state_t next_state;
	logic [9:0]  wr_ptr;
	logic [9:0]  next_wr_ptr;
	logic        buf_full;
	logic [7:0]  upper_byte;

	// read ahead of the logic that drives them: the slave
	// instance and the status word both use these
	logic        wr_hit;
	logic        rd_hit;
	logic        capturing;

	efcc_axil_slave u_slave
	(
		.clk_in          (clk_in),
		.rst_b_in        (rst_b_in),
		.awaddr_in       (awaddr_in),
		.awvalid_in      (awvalid_in),
		.awready_out     (awready_out),
		.wdata_in        (wdata_in),
		.wstrb_in        (wstrb_in),
		.wvalid_in       (wvalid_in),
		.wready_out      (wready_out),
		.bresp_out       (bresp_out),
		.bvalid_out      (bvalid_out),
		.bready_in       (bready_in),
		.araddr_in       (araddr_in),
		.arvalid_in      (arvalid_in),
		.arready_out     (arready_out),
		.rdata_out       (rdata_out),
		.rresp_out       (rresp_out),
		.rvalid_out      (rvalid_out),
		.rready_in       (rready_in),
		.reg_wr_out      (reg_wr),
		.reg_wr_addr_out (reg_wr_addr),
		.reg_wr_data_out (reg_wr_data),
		.reg_wr_strb_out (reg_wr_strb),
		.reg_wr_hit_in   (wr_hit),
		.reg_rd_addr_out (reg_rd_addr),
		.reg_rd_data_in  (reg_rd_data),
		.reg_rd_hit_in   (rd_hit)
	);

	// write decode; registers sit in byte lane 0 only
	wire       lane0      = reg_wr & reg_wr_strb[0];
	wire       wr_power   = lane0 & (reg_wr_addr == ADDR_POWER_MODE);
	wire       wr_dpath   = lane0 & (reg_wr_addr == ADDR_DATAPATH);
	wire       wr_sbuf    = lane0 & (reg_wr_addr == ADDR_SAMPLE_BUF);
	wire       wr_enable  = lane0 & (reg_wr_addr == ADDR_ENABLE);
	wire [7:0] wbyte      = reg_wr_data[7:0];
	assign wr_hit = (reg_wr_addr == ADDR_POWER_MODE) | (reg_wr_addr == ADDR_DATAPATH)
	                      | (reg_wr_addr == ADDR_SAMPLE_BUF) | (reg_wr_addr == ADDR_ENABLE)
	                      | (reg_wr_addr == ADDR_BUF_STATUS);

	// control bits pulled out of the registers
	wire       measure_active = power_mode_control[POS_MEASURE_ACTIVE];
	wire       raw_adc_source = datapath_source_control[POS_FIFO_SOURCE];
	wire       filter_bypass  = datapath_source_control[POS_FILTER_BYPASS];
	wire [1:0] format_sel     = sample_buffer_control[POS_FORMAT_LO +: 2];
	wire       rollover_off   = sample_buffer_control[POS_ROLLOVER_OFF];
	wire       echo_enable    = enable_control[POS_ECHO_ENABLE];
	wire       echo_start     = wr_enable & wbyte[POS_ECHO_ENABLE] & ~echo_enable;

	// transmit enable: set by software, cleared by the serial engine; a set wins
	wire       tx_set   = wr_dpath & wbyte[POS_SERIAL_TX];
	wire       tx_state = tx_set | (datapath_source_control[POS_SERIAL_TX]
	                              & ~serial_transmit_done_in);

	// register file
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			power_mode_control      <= RST_POWER_MODE;
			datapath_source_control <= RST_DATAPATH;
			sample_buffer_control   <= RST_SAMPLE_BUF;
			enable_control          <= RST_ENABLE;
		end
		else
		begin
			if (wr_power)
				power_mode_control <= wbyte;
			datapath_source_control[POS_SERIAL_TX] <= tx_state;
			if (wr_dpath)
			begin
				datapath_source_control[7:2] <= wbyte[7:2];
				datapath_source_control[0]   <= wbyte[0];
			end
			if (wr_sbuf)
				sample_buffer_control <= wbyte;
			if (wr_enable)
				enable_control <= wbyte;
		end
	end

	// read decode; the status word exposes the capture engine
	wire [31:0] buf_status = {18'h0, (state == ST_UPPER), capturing, buf_full, 1'b0, wr_ptr};
	wire        rd_power   = reg_rd_addr == ADDR_POWER_MODE;
	wire        rd_dpath   = reg_rd_addr == ADDR_DATAPATH;
	wire        rd_sbuf    = reg_rd_addr == ADDR_SAMPLE_BUF;
	wire        rd_enable  = reg_rd_addr == ADDR_ENABLE;
	wire        rd_status  = reg_rd_addr == ADDR_BUF_STATUS;
	assign rd_hit = rd_power | rd_dpath | rd_sbuf | rd_enable | rd_status;
	assign reg_rd_data = rd_power  ? {24'h0, power_mode_control}
	                   : rd_dpath  ? {24'h0, datapath_source_control}
	                   : rd_sbuf   ? {24'h0, sample_buffer_control}
	                   : rd_enable ? {24'h0, enable_control}
	                   : rd_status ? buf_status
	                   : 32'h0000_0000;

	// sample selection ahead of packing
	wire [11:0] dp_sample  = filter_bypass ? peak_sample_in : lowpass_sample_in;
	wire [11:0] buf_sample = raw_adc_source ? adc_sample_in : dp_sample;
	wire [7:0]  first_byte;
	wire [7:0]  second_byte;
	wire        two_bytes;

	efcc_sample_packer u_packer
	(
		.sample_in       (buf_sample),
		.format_in       (format_sel),
		.first_byte_out  (first_byte),
		.second_byte_out (second_byte),
		.two_bytes_out   (two_bytes)
	);

	// capture gate: measurement circuitry, echo enable and blanking all needed
	// samples offered while not capturing are still taken, then dropped
	assign capturing = measure_active & echo_enable & blanking_expired_in;
	wire accept    = (state == ST_TAKE) & sample_valid_in & sample_ready_out;
	wire at_end    = (wr_ptr == LAST_ADDR);
	// with rollover off, a two-byte sample needs two free bytes
	wire room      = ~buf_full & ~(rollover_off & two_bytes & at_end);
	wire do_write  = accept & capturing & room;
	wire wr_upper  = (state == ST_UPPER);
	wire step      = do_write | wr_upper;
	// pointer advance: wrap to zero unless rollover is off
	wire [9:0] ptr_inc  = at_end ? 10'h000 : wr_ptr + 10'h001;
	wire       fill_end = step & at_end & rollover_off;

	// next pointer and state
	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_state  = state;
		if (step && !fill_end)
			next_wr_ptr = ptr_inc;
		unique case (state)
			ST_TAKE:  if (do_write && two_bytes) next_state = ST_UPPER;
			ST_UPPER: next_state = ST_TAKE;
		endcase
	end

	// capture engine; the stream is held off while the upper byte goes out
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			state            <= ST_TAKE;
			wr_ptr           <= 10'h000;
			buf_full         <= 1'b0;
			upper_byte       <= 8'h00;
			sample_ready_out <= 1'b1;
			buf_write_out    <= '0;
		end
		else if (echo_start)
		begin
			state            <= ST_TAKE;   // a new echo run starts at address zero
			wr_ptr           <= 10'h000;
			buf_full         <= 1'b0;
			sample_ready_out <= 1'b1;
			buf_write_out    <= '0;
		end
		else
		begin
			state            <= next_state;
			wr_ptr           <= next_wr_ptr;
			buf_full         <= buf_full | fill_end;
			sample_ready_out <= (next_state == ST_TAKE);
			buf_write_out.en <= step;
			if (do_write)
			begin
				upper_byte          <= second_byte;
				buf_write_out.addr  <= wr_ptr;
				buf_write_out.data  <= first_byte;
			end
			else if (wr_upper)
			begin
				buf_write_out.addr  <= wr_ptr;
				buf_write_out.data  <= upper_byte;
			end
		end
	end

	// analog and mode outputs, registered so they change cleanly
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			analog_enable_out          <= '0;
			boost_supply_enable_out    <= 1'b0;
			filter_bypass_select_out   <= 1'b0;
			serial_transmit_enable_out <= 1'b0;
		end
		else
		begin
			analog_enable_out          <= {7{measure_active}};
			boost_supply_enable_out    <= power_mode_control[POS_BOOST_SUPPLY];
			filter_bypass_select_out   <= filter_bypass;
			serial_transmit_enable_out <= tx_state;
		end
	end

endmodule : efcc_top

// ---- design/efcc_pkg.sv ----
package efcc_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_POWER_MODE = 8'hc3;
	localparam logic [7:0] IDX_DATAPATH   = 8'hc4;
	localparam logic [7:0] IDX_SAMPLE_BUF = 8'hc5;
	localparam logic [7:0] IDX_ENABLE     = 8'hc8;
	localparam logic [7:0] IDX_BUF_STATUS = 8'he0;

	localparam int AXI_ADDR_W = 12;
	localparam logic [11:0] ADDR_POWER_MODE = {2'b00, IDX_POWER_MODE, 2'b00};
	localparam logic [11:0] ADDR_DATAPATH   = {2'b00, IDX_DATAPATH, 2'b00};
	localparam logic [11:0] ADDR_SAMPLE_BUF = {2'b00, IDX_SAMPLE_BUF, 2'b00};
	localparam logic [11:0] ADDR_ENABLE     = {2'b00, IDX_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_BUF_STATUS = {2'b00, IDX_BUF_STATUS, 2'b00};

	// field positions
	localparam int POS_MEASURE_ACTIVE = 0;
	localparam int POS_BOOST_SUPPLY   = 1;
	localparam int POS_FILTER_BYPASS  = 0;
	localparam int POS_SERIAL_TX      = 1;
	localparam int POS_FIFO_SOURCE    = 2;
	localparam int POS_FORMAT_LO      = 0;
	localparam int POS_ROLLOVER_OFF   = 2;
	localparam int POS_ECHO_ENABLE    = 3;

	// reset values
	localparam logic [7:0] RST_POWER_MODE = 8'h00;
	localparam logic [7:0] RST_DATAPATH   = 8'h00;
	localparam logic [7:0] RST_SAMPLE_BUF = 8'h00;
	localparam logic [7:0] RST_ENABLE     = 8'h00;

	localparam int          BUF_BYTES  = 768;
	localparam logic [7:0]  SAT_BYTE   = 8'hff;
	localparam logic [1:0]  AXI_OKAY   = 2'b00;
	localparam logic [1:0]  AXI_SLVERR = 2'b10;

	typedef enum logic [1:0]
	{
		FMT_FULL12 = 2'b00,
		FMT_UPPER8 = 2'b01,
		FMT_LOWER8 = 2'b10,
		FMT_MID8   = 2'b11
	} efcc_format_t;

	// enables of the measurement circuitry, all gated together
	typedef struct packed
	{
		logic eeprom;
		logic supply_monitor;
		logic lna;
		logic ls_diag;
		logic driver_output_a;
		logic driver_output_b;
		logic adc;
	} efcc_analog_en_t;

	// one byte write toward the sample RAM
	typedef struct packed
	{
		logic       en;
		logic [9:0] addr;
		logic [7:0] data;
	} efcc_buf_wr_t;

endpackage : efcc_pkg

// ---- design/efcc_sample_packer.sv ----
`timescale 1ns/1ns
// turns one 12-bit sample into one or two bytes for the sample RAM
module efcc_sample_packer
	import efcc_pkg::*;
(
	// sample and format
	input  wire logic [11:0] sample_in,
	input  wire logic [1:0]  format_in,
	// packed bytes
	output logic [7:0]       first_byte_out,
	output logic [7:0]       second_byte_out,
	output logic             two_bytes_out
);

	wire efcc_format_t fmt        = efcc_format_t'(format_in);
	wire               sat_lower  = |sample_in[11:8];
	wire               sat_mid    = sample_in[11];

	// byte selection; saturation clamps instead of wrapping around
	always_comb
	begin
		first_byte_out  = sample_in[7:0];
		second_byte_out = {4'h0, sample_in[11:8]};
		two_bytes_out   = 1'b0;
		unique case (fmt)
			FMT_FULL12:
			begin
				first_byte_out = sample_in[7:0];
				two_bytes_out  = 1'b1;
			end
			FMT_UPPER8: first_byte_out = sample_in[11:4];
			FMT_LOWER8: first_byte_out = sat_lower ? SAT_BYTE : sample_in[7:0];
			FMT_MID8:   first_byte_out = sat_mid ? SAT_BYTE : sample_in[10:3];
		endcase
	end

endmodule : efcc_sample_packer

// ---- design/efcc_axil_slave.sv ----
`timescale 1ns/1ns
// axi4-lite slave; address and data may arrive in either order
module efcc_axil_slave
	import efcc_pkg::*;
(
	// clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rst_b_in,
	// write channels
	input  wire logic [AXI_ADDR_W-1:0] awaddr_in,
	input  wire logic                  awvalid_in,
	output logic                       awready_out,
	input  wire logic [31:0]           wdata_in,
	input  wire logic [3:0]            wstrb_in,
	input  wire logic                  wvalid_in,
	output logic                       wready_out,
	output logic [1:0]                 bresp_out,
	output logic                       bvalid_out,
	input  wire logic                  bready_in,
	// read channels
	input  wire logic [AXI_ADDR_W-1:0] araddr_in,
	input  wire logic                  arvalid_in,
	output logic                       arready_out,
	output logic [31:0]                rdata_out,
	output logic [1:0]                 rresp_out,
	output logic                       rvalid_out,
	input  wire logic                  rready_in,
	// register side
	output logic                       reg_wr_out,
	output logic [AXI_ADDR_W-1:0]      reg_wr_addr_out,
	output logic [31:0]                reg_wr_data_out,
	output logic [3:0]                 reg_wr_strb_out,
	input  wire logic                  reg_wr_hit_in,
	output logic [AXI_ADDR_W-1:0]      reg_rd_addr_out,
	input  wire logic [31:0]           reg_rd_data_in,
	input  wire logic                  reg_rd_hit_in
);

	logic aw_held;
	logic w_held;

	wire aw_take  = awvalid_in & awready_out;
	wire w_take   = wvalid_in & wready_out;
	wire wr_fire  = aw_held & w_held & ~bvalid_out;
	wire ar_take  = arvalid_in & arready_out;

	// write path: hold each half until both are present
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			awready_out     <= 1'b1;
			wready_out      <= 1'b1;
			bvalid_out      <= 1'b0;
			bresp_out       <= AXI_OKAY;
			reg_wr_out      <= 1'b0;
			reg_wr_addr_out <= '0;
			reg_wr_data_out <= '0;
			reg_wr_strb_out <= '0;
		end
		else
		begin
			reg_wr_out <= wr_fire;
			if (aw_take)
			begin
				aw_held         <= 1'b1;
				awready_out     <= 1'b0;
				reg_wr_addr_out <= awaddr_in;
			end
			if (w_take)
			begin
				w_held          <= 1'b1;
				wready_out      <= 1'b0;
				reg_wr_data_out <= wdata_in;
				reg_wr_strb_out <= wstrb_in;
			end
			if (wr_fire)
			begin
				bvalid_out <= 1'b1;
				bresp_out  <= reg_wr_hit_in ? AXI_OKAY : AXI_SLVERR;
			end
			if (bvalid_out && bready_in)
			begin
				bvalid_out  <= 1'b0;
				aw_held     <= 1'b0;
				w_held      <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	assign reg_rd_addr_out = araddr_in;

	// read path: data sampled at the address handshake
	always_ff @(posedge clk_in)
	begin
		if (!rst_b_in)
		begin
			arready_out <= 1'b1;
			rvalid_out  <= 1'b0;
			rdata_out   <= '0;
			rresp_out   <= AXI_OKAY;
		end
		else if (ar_take)
		begin
			arready_out <= 1'b0;
			rvalid_out  <= 1'b1;
			rdata_out   <= reg_rd_data_in;
			rresp_out   <= reg_rd_hit_in ? AXI_OKAY : AXI_SLVERR;
		end
		else if (rvalid_out && rready_in)
		begin
			rvalid_out  <= 1'b0;
			arready_out <= 1'b1;
		end
	end

endmodule : efcc_axil_slave

// ---- verif/efcc_properties.sv ----
`timescale 1ns/1ns
// watches the top ports; control outputs may move only around a write response, except transmit enable clearing on done
module efcc_properties
	import efcc_pkg::*;
#(
	parameter int BUF_DEPTH = BUF_BYTES
)
(
	// clock and reset
	input wire logic            clk_in,
	input wire logic            rst_b_in,
	// bus answers
	input wire logic            bvalid_out,
	input wire logic            rvalid_out,
	input wire logic [31:0]     rdata_out,
	// controls
	input wire efcc_analog_en_t analog_enable_out,
	input wire logic            boost_supply_enable_out,
	input wire logic            filter_bypass_select_out,
	input wire logic            serial_transmit_enable_out,
	input wire logic            serial_transmit_done_in,
	// sample stream
	input wire logic            blanking_expired_in,
	input wire efcc_buf_wr_t    buf_write_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// a change with no response nearby means a register moved by itself
	AST_ANALOG_GANG: assert property (analog_enable_out == {7{analog_enable_out.adc}})
		else $error("analog enables disagree");
	AST_ANALOG_BY_WRITE: assert property ($changed(analog_enable_out) |-> $past(bvalid_out) || $past(bvalid_out, 2))
		else $error("analog enables moved without a write");
	AST_BOOST_BY_WRITE: assert property ($changed(boost_supply_enable_out) |-> $past(bvalid_out) || $past(bvalid_out, 2))
		else $error("boost enable moved without a write");
	AST_BYPASS_BY_WRITE: assert property ($changed(filter_bypass_select_out) |-> $past(bvalid_out) || $past(bvalid_out, 2))
		else $error("filter select moved without a write");
	AST_TX_CLEAR: assert property ($fell(serial_transmit_enable_out) |-> $past(serial_transmit_done_in))
		else $error("transmit enable cleared without done");
	AST_TX_SET: assert property ($rose(serial_transmit_enable_out) |-> bvalid_out || $past(bvalid_out))
		else $error("transmit enable set without a write");
	AST_CAPTURE_BLANK: assert property (buf_write_out.en |-> $past(blanking_expired_in) || $past(blanking_expired_in, 2))
		else $error("byte written before blanking expired");
	AST_ADDR_RANGE: assert property (buf_write_out.en |-> buf_write_out.addr < BUF_DEPTH)
		else $error("write address beyond buffer");
	AST_ADDR_STEP: assert property (buf_write_out.en && $past(buf_write_out.en) |-> buf_write_out.addr == $past(buf_write_out.addr) + 10'h1 || buf_write_out.addr == 10'h0)
		else $error("consecutive bytes not at consecutive addresses");
	AST_RDATA_UPPER: assert property (rvalid_out |-> rdata_out[31:14] == 18'h0)
		else $error("read data upper bits not zero");
endmodule : efcc_properties

bind efcc_top efcc_properties #(.BUF_DEPTH(BUF_DEPTH)) efcc_properties_i (.*);

// ---- verif/efcc_sample_source.sv ----
`timescale 1ns/1ns
// stands in for the datapath and adc; the three candidates differ so a wrong pick shows
module efcc_sample_source
	import efcc_pkg::*;
(
	// clock and handshake
	input  wire logic   clk_in,
	input  wire logic   sample_ready_in,
	// candidates
	output logic [11:0] lowpass_out,
	output logic [11:0] peak_out,
	output logic [11:0] adc_out,
	output logic        valid_out
);
	// idle state at time zero
	initial
	begin
		lowpass_out = 12'h000;
		peak_out = 12'h000;
		adc_out = 12'h000;
		valid_out = 1'h0;
	end

	// holds the sample until taken, then shows the inverse so a late sample never matches
	task automatic send(input logic [11:0] v);
		@(posedge clk_in);
		lowpass_out <= v;
		peak_out <= v ^ 12'h0f0;
		adc_out <= v ^ 12'hf00;
		valid_out <= 1'h1;
		do @(posedge clk_in); while (!sample_ready_in);
		valid_out <= 1'h0;
		lowpass_out <= ~v;
		peak_out <= ~v;
		adc_out <= ~v;
	endtask : send
endmodule : efcc_sample_source

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
// register writes, stream capture in every format and source, blanking and rollover
module testbench;
	import efcc_pkg::*;
	localparam int DEP = 16;
	logic            clk_in, rst_b_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
	logic [11:0]     awaddr_in, araddr_in, lowpass_sample_in, peak_sample_in, adc_sample_in;
	logic [31:0]     wdata_in, rdata_out;
	logic [3:0]      wstrb_in;
	logic            awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic [1:0]      bresp_out, rresp_out;
	logic            sample_valid_in, sample_ready_out, blanking_expired_in;
	logic            serial_transmit_done_in, serial_transmit_enable_out;
	logic            boost_supply_enable_out, filter_bypass_select_out;
	efcc_analog_en_t analog_enable_out;
	efcc_buf_wr_t    buf_write_out;
	logic [17:0]     q[$];
	logic [11:0]     smp[4] = '{12'h8a5, 12'h0f3, 12'h07c, 12'h4c1};
	int              n_fail, comparisons, f, sel;

	efcc_top #(.BUF_DEPTH(DEP)) efcc_top_i (.*);
	efcc_sample_source efcc_sample_source_i (.clk_in(clk_in), .sample_ready_in(sample_ready_out),
		.lowpass_out(lowpass_sample_in), .peak_out(peak_sample_in), .adc_out(adc_sample_in),
		.valid_out(sample_valid_in));

	// clock
	initial
	begin
		clk_in = 1'h0;
		forever #4 clk_in = ~clk_in;
	end

	// records every byte that reaches the sample ram
	always @(posedge clk_in)
		if (rst_b_in && buf_write_out.en)
			q.push_back({buf_write_out.addr, buf_write_out.data});

	// each channel released at its own handshake; response waited for under a bound
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk_in);
		awaddr_in <= a;
		wdata_in <= {24'h0, d};
		awvalid_in <= 1'h1;
		wvalid_in <= 1'h1;
		bready_in <= 1'h1;
		for (int t = 0; t < 50 && !bvalid_out; t++)
		begin
			@(posedge clk_in);
			if (awvalid_in && awready_out)
				awvalid_in <= 1'h0;
			if (wvalid_in && wready_out)
				wvalid_in <= 1'h0;
		end
		bready_in <= 1'h0;
		`CHK(bvalid_out, 1'h1)
		`CHK(bresp_out, er)
		// registered controls settle one edge after the register itself
		repeat (2) @(posedge clk_in);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk_in);
		araddr_in <= a;
		arvalid_in <= 1'h1;
		rready_in <= 1'h1;
		for (int t = 0; t < 50 && !rvalid_out; t++)
		begin
			@(posedge clk_in);
			if (arvalid_in && arready_out)
				arvalid_in <= 1'h0;
		end
		rready_in <= 1'h0;
		`CHK(rvalid_out, 1'h1)
		`CHK(rdata_out, {24'h0, d})
		`CHK(rresp_out, er)
	endtask : rd

	// bytes expected for one sample: low byte in [7:0], second byte of the wide format in [15:8]
	function automatic logic [15:0] pack(input logic [11:0] s, input logic [1:0] m);
		case (m)
			2'h0: pack = {4'h0, s};
			2'h1: pack = {8'h0, s[11:4]};
			2'h2: pack = {8'h0, (|s[11:8]) ? 8'hff : s[7:0]};
			default: pack = {8'h0, s[11] ? 8'hff : s[10:3]};
		endcase
	endfunction : pack

	// one capture run from a re-armed pointer; m[2] turns rollover off
	task automatic run(input logic [2:0] m, input logic [1:0] src, input int n);
		int          cnt;
		logic [11:0] s;
		logic [15:0] e;
		wr(ADDR_DATAPATH, {5'h0, src == 2'h2, 1'h0, src == 2'h1}, AXI_OKAY);
		wr(ADDR_SAMPLE_BUF, {5'h0, m}, AXI_OKAY);
		wr(ADDR_ENABLE, 8'h00, AXI_OKAY);
		wr(ADDR_ENABLE, 8'h08, AXI_OKAY);
		q.delete();
		for (int k = 0; k < n; k++)
			efcc_sample_source_i.send(smp[k % 4]);
		repeat (3) @(posedge clk_in);
		cnt = blanking_expired_in ? (m[1:0] == 2'h0 ? 2 * n : n) : 0;
		if (m[2] && cnt > DEP)
			cnt = DEP;
		`CHK(q.size(), cnt)
		if (q.size() == cnt)
			for (int k = 0; k < cnt; k++)
			begin
				s = smp[(m[1:0] == 2'h0 ? k / 2 : k) % 4];
				s = src == 2'h2 ? s ^ 12'hf00 : src == 2'h1 ? s ^ 12'h0f0 : s;
				e = pack(s, m[1:0]);
				`CHK(q.pop_front(), {10'(k % DEP), (m[1:0] == 2'h0 && k % 2) ? e[15:8] : e[7:0]})
			end
	endtask : run

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	// watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		repeat (40000) @(posedge clk_in);
		n_fail++;
		final_report;
	end

	// main sequence
	initial
	begin
		{awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
		{awaddr_in, araddr_in, wdata_in} = 56'h0;
		wstrb_in = 4'hf;
		rst_b_in = 1'h0;
		blanking_expired_in = 1'h1;
		serial_transmit_done_in = 1'h0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'h1;
		rd(ADDR_POWER_MODE, RST_POWER_MODE, AXI_OKAY);
		rd(ADDR_DATAPATH, RST_DATAPATH, AXI_OKAY);
		rd(ADDR_SAMPLE_BUF, RST_SAMPLE_BUF, AXI_OKAY);
		rd(ADDR_ENABLE, RST_ENABLE, AXI_OKAY);
		`CHK(analog_enable_out, 7'h00)
		rd(12'h004, 8'h00, AXI_SLVERR);
		wr(12'h004, 8'h5a, AXI_SLVERR);
		$display("test reset_map done");
		wr(ADDR_POWER_MODE, 8'h02, AXI_OKAY);
		`CHK(boost_supply_enable_out, 1'h1)
		`CHK(analog_enable_out, 7'h00)
		wr(ADDR_POWER_MODE, 8'h01, AXI_OKAY);
		`CHK(boost_supply_enable_out, 1'h0)
		`CHK(analog_enable_out, 7'h7f)
		rd(ADDR_POWER_MODE, 8'h01, AXI_OKAY);
		wr(ADDR_DATAPATH, 8'h03, AXI_OKAY);
		`CHK({serial_transmit_enable_out, filter_bypass_select_out}, 2'h3)
		wr(ADDR_DATAPATH, 8'h00, AXI_OKAY);
		`CHK({serial_transmit_enable_out, filter_bypass_select_out}, 2'h2)
		serial_transmit_done_in <= 1'h1;
		@(posedge clk_in);
		serial_transmit_done_in <= 1'h0;
		@(posedge clk_in);
		`CHK(serial_transmit_enable_out, 1'h0)
		$display("test controls done");
		for (f = 0; f < 4; f++)
			for (sel = 0; sel < 3; sel++)
				run(f[2:0], sel[1:0], 4);
		$display("test formats done");
		blanking_expired_in <= 1'h0;
		run(3'h1, 2'h0, 2);
		blanking_expired_in <= 1'h1;
		run(3'h1, 2'h0, 20);
		run(3'h5, 2'h0, 20);
		run(3'h4, 2'h0, 10);
		$display("test blanking_rollover done");
		final_report;
	end
endmodule : testbench
